/* lprm_ctrl.sv */
// Low-power, restart and wake mode controller of the supply chip
`timescale 1ns/1ps
`default_nettype none
`include "lprm_defines.svh"

// Contract
// R1: Stop mode ignores writes, flags SPI fault; mode, soft reset, refresh, status pass.
// R2: Stop mode wake asserts interrupt without changing mode.
// R3: Stop mode freezes Normal-mode settings; main supply stays on.
// R4: Wake flag still set at Stop entry asserts interrupt.
// R5: Sleep requested from Stop flags SPI fault and goes to Restart.
// R6: Measurement select 1 blocks sense and GPIO pins as wake sources.
// R7: Sleep wake goes via Restart to Normal and records the source.
// R8: Sleep entry turns an on or receive-only transceiver wake-capable.
// R9: Sleep stops watchdog, holds reset low, disables I/O, records state.
// R10: Sleep request with no wake source flags fault and goes to Restart.
// R11: Sleep entry with wake flag set wakes at once via Restart.
// R12: Host finishes configuration and clears wake flags before low power.
// R13: Main undervoltage restarts from Normal, Stop, or Init after reset release.
// R14: Overvoltage restarts only with enable set and config pin 1.
// R15: First bad watchdog trigger restarts, except config 2 goes fail-safe.
// R16: Wake in Sleep or fail-safe, or thermal release, enters Restart.
// R17: Restart moves automatically to Normal and clears mode bits.
// R18: Reset output low in Restart, released after reset delay into Normal.
// R19: Reset rising edge starts long open window, period reloads to 100.
// R20: Fail output set by watchdog count or overvoltage; stays after Restart.
// R21: Restart drops aux supply, GPIO switch, SPI; transceiver becomes wake-capable (code leaves an off transceiver off).
// R22: Status reads restart 01, sleep 10, fail count, under/overvoltage flags.
// R23: Soft reset command returns to Init and reloads unlocked settings.
module lprm_ctrl #(
   parameter int RESET_DELAY_CYC = `LPRM_RESET_DELAY_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire lprm_pkg::lprm_cmd_t cmd,
   input wire lprm_pkg::lprm_cfg_t cfg_wr,
   input wire lprm_pkg::lprm_wake_t wake_en_wr,
   input wire logic cfg_lock,
   input wire logic measurement_select,
   input wire logic main_overvolt_reset_enable,
   input wire logic cfg1_bit,
   input wire logic config0_pin,
   input wire logic main_uv_pin,
   input wire logic main_ov_pin,
   input wire logic thermal_shutdown_level2_pin,
   input wire lprm_pkg::lprm_wake_t wake_evt_in,
   input wire logic wd_bad_trigger,
   input wire logic fail_clear,
   output lprm_pkg::lprm_state_t state_q,
   output lprm_pkg::lprm_cfg_t cfg_q,
   output lprm_pkg::lprm_wake_t wake_status_q,
   output lprm_pkg::lprm_stat_t stat_q,
   output logic interrupt_out_n,
   output logic reset_out_n,
   output logic fail_output,
   output logic main_supply_on,
   output logic watchdog_run,
   output logic wd_long_open,
   output logic io_enable
);
   // Pin inputs are synchronised twice before any decision reads them
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   lprm_pkg::lprm_wake_t wk_s1_q;
   lprm_pkg::lprm_wake_t wk_s2_q;
   logic cfg0_s1_q;
   logic cfg0_s2_q;
   always_ff @(posedge clock) begin
      pin_s1_q <= {main_uv_pin, main_ov_pin, thermal_shutdown_level2_pin};
      pin_s2_q <= pin_s1_q;
      wk_s1_q <= wake_evt_in;
      wk_s2_q <= wk_s1_q;
      cfg0_s1_q <= config0_pin;
      cfg0_s2_q <= cfg0_s1_q;
   end

   wire uv = pin_s2_q[2];
   wire ov = pin_s2_q[1];
   wire thermal_shutdown_level2 = pin_s2_q[0];

   lprm_pkg::lprm_state_t state_d;
   lprm_pkg::lprm_wake_t wake_en_q;
   logic thermal_shutdown_level2_seen_q;
   logic rst_released_q;
   logic [1:0] wd_fails_q;
   logic [15:0] delay_q;
   logic int_stop_q;

   // Command qualification per mode
   wire in_stop = (state_q == lprm_pkg::ST_STOP);
   wire in_sleep = (state_q == lprm_pkg::ST_SLEEP);
   wire in_restart = (state_q == lprm_pkg::ST_RESTART);
   wire in_fs = (state_q == lprm_pkg::ST_FAILSAFE);
   wire spi_live = cmd.valid && !in_restart && !in_sleep && !in_fs; // [R21] [R9]
   wire mode_cmd = spi_live && cmd.mode_write;
   wire stop_mode_ok = mode_cmd && (cmd.mode == `LPRM_CMD_NORMAL
      || cmd.mode == `LPRM_CMD_SOFTRST);
   wire stop_write_bad = in_stop && spi_live && cmd.is_write
      && !stop_mode_ok && !cmd.wd_refresh && !cmd.status_clear; // [R1]
   wire cfg_write = spi_live && cmd.is_write && !in_stop && !cmd.mode_write; // [R1] [R3]
   wire soft_rst = mode_cmd && cmd.mode == `LPRM_CMD_SOFTRST; // [R23]
   wire sleep_req = mode_cmd && cmd.mode == `LPRM_CMD_SLEEP;

   // Measurement function takes the sense and GPIO pins away from waking
   lprm_pkg::lprm_wake_t wake_en_eff;
   assign wake_en_eff = '{trx: wake_en_q.trx, timer: wake_en_q.timer,
      sense: wake_en_q.sense && !measurement_select,
      gpio: wake_en_q.gpio && !measurement_select}; // [R6]
   wire [3:0] wake_hit = wk_s2_q & wake_en_eff;
   wire any_wake_en = |wake_en_eff;
   wire any_flag = |wake_status_q;
   wire sleep_bad = sleep_req && (in_stop || !any_wake_en); // [R5] [R10]

   // Watchdog and overvoltage failure classification
   wire watchdog_fail_count_evt = watchdog_run && wd_bad_trigger;
   wire cfg_pull = cfg0_s2_q;
   wire wd_to_fs = watchdog_fail_count_evt && (cfg_pull ? 1'b0
      : (cfg1_bit || wd_fails_q != 2'h0)); // [R15]
   wire ov_evt = ov && main_overvolt_reset_enable;
   wire restart_evt = (uv && (state_q == lprm_pkg::ST_NORMAL || in_stop
      || (state_q == lprm_pkg::ST_INIT && rst_released_q))) // [R13]
      || (ov_evt && cfg_pull) // [R14]
      || (watchdog_fail_count_evt && !wd_to_fs); // [R15]
   wire delay_done = (delay_q == 16'(RESET_DELAY_CYC - 1));

   // Next mode
   always_comb begin
      state_d = state_q;
      case (state_q)
         lprm_pkg::ST_INIT: begin
            if (restart_evt) begin
               state_d = lprm_pkg::ST_RESTART;
            end else if (wd_to_fs || (ov_evt && !cfg_pull)) begin
               state_d = lprm_pkg::ST_FAILSAFE;
            end else if (spi_live) begin
               state_d = lprm_pkg::ST_NORMAL;
            end
         end
         lprm_pkg::ST_NORMAL, lprm_pkg::ST_STOP: begin
            if (restart_evt || sleep_bad) begin
               state_d = lprm_pkg::ST_RESTART; // [R5] [R10] [R13]
            end else if (wd_to_fs || (ov_evt && !cfg_pull) || thermal_shutdown_level2) begin
               state_d = lprm_pkg::ST_FAILSAFE;
            end else if (soft_rst) begin
               state_d = lprm_pkg::ST_INIT; // [R23]
            end else if (mode_cmd && cmd.mode == `LPRM_CMD_NORMAL) begin
               state_d = lprm_pkg::ST_NORMAL;
            end else if (sleep_req) begin
               state_d = lprm_pkg::ST_SLEEP;
            end else if (mode_cmd && cmd.mode == `LPRM_CMD_STOP && !in_stop) begin
               state_d = lprm_pkg::ST_STOP;
            end
         end
         lprm_pkg::ST_SLEEP: begin
            if (|wake_hit || any_flag) begin
               state_d = lprm_pkg::ST_RESTART; // [R7] [R11] [R16]
            end
         end
         lprm_pkg::ST_FAILSAFE: begin
            if (|wake_hit || (thermal_shutdown_level2_seen_q && !thermal_shutdown_level2)) begin
               state_d = lprm_pkg::ST_RESTART; // [R16]
            end
         end
         lprm_pkg::ST_RESTART: begin
            if (delay_done) begin
               state_d = lprm_pkg::ST_NORMAL; // [R17] [R18]
            end
         end
         default: state_d = lprm_pkg::ST_INIT;
      endcase
   end

   wire enter_restart = state_d == lprm_pkg::ST_RESTART && !in_restart;
   wire enter_sleep = state_d == lprm_pkg::ST_SLEEP && !in_sleep;
   wire enter_stop = state_d == lprm_pkg::ST_STOP && !in_stop;
   wire leave_restart = in_restart && delay_done;

   // Mode register, reset delay counter and failure bookkeeping
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_q <= lprm_pkg::ST_INIT;
         delay_q <= 16'h0000;
         thermal_shutdown_level2_seen_q <= 1'b0;
         rst_released_q <= 1'b0;
         wd_fails_q <= 2'h0;
      end else begin
         state_q <= state_d;
         delay_q <= in_restart ? delay_q + 16'h0001 : 16'h0000; // [R18]
         thermal_shutdown_level2_seen_q <= in_fs ? (thermal_shutdown_level2_seen_q || thermal_shutdown_level2) : thermal_shutdown_level2;
         if (leave_restart || (state_q == lprm_pkg::ST_INIT && !rst_released_q)) begin
            rst_released_q <= 1'b1;
         end
         if (watchdog_fail_count_evt && wd_fails_q != 2'h2) begin
            wd_fails_q <= wd_fails_q + 2'h1;
         end else if (cmd.wd_refresh && spi_live) begin
            wd_fails_q <= 2'h0;
         end
      end
   end

   // Settings: written only outside Stop, reloaded by soft reset, forced by Sleep and Restart entry
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cfg_q <= '0;
         cfg_q.wd_period <= `LPRM_WD_PERIOD_DEFAULT;
         wake_en_q <= '{trx: 1'b1, sense: 1'b1, gpio: 1'b0, timer: 1'b0};
      end else if (soft_rst && !cfg_lock) begin
         cfg_q <= '0; // [R23]
         cfg_q.wd_period <= `LPRM_WD_PERIOD_DEFAULT;
      end else if (enter_restart) begin
         cfg_q.aux_on <= 1'b0; // [R21]
         cfg_q.gpio_sw_on <= 1'b0;
         if (cfg_q.trx_mode != `LPRM_TRX_OFF) begin
            cfg_q.trx_mode <= `LPRM_TRX_WAKE; // [R21]
         end
      end else if (leave_restart) begin
         cfg_q.wd_period <= `LPRM_WD_PERIOD_DEFAULT; // [R19]
      end else if (enter_sleep && cfg_q.trx_mode != `LPRM_TRX_OFF) begin
         cfg_q.trx_mode <= `LPRM_TRX_WAKE; // [R8]
      end else if (cfg_write) begin
         cfg_q <= cfg_wr; // [R3]
         wake_en_q <= wake_en_wr;
      end
   end

   // Wake flags: capture beats a clear in the same cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wake_status_q <= '0;
      end else if (state_d == lprm_pkg::ST_FAILSAFE && !in_fs) begin
         // Events from before fail-safe are dropped on entry
         wake_status_q <= '0;
      end else begin
         wake_status_q <= (cmd.status_clear && spi_live ? '0 : wake_status_q)
            | ((state_q != lprm_pkg::ST_INIT) ? wake_hit : 4'h0); // [R7]
      end
   end

   // Status field and fail output; set wins over clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stat_q <= '0;
         fail_output <= 1'b0;
      end else begin
         if (cmd.status_clear && spi_live) begin
            stat_q <= '0;
         end
         if (enter_restart) begin
            stat_q.device_state_field <= in_sleep ? `LPRM_DEVSTAT_SLEEP
               : `LPRM_DEVSTAT_RESTART; // [R22]
         end else if (enter_sleep) begin
            stat_q.device_state_field <= `LPRM_DEVSTAT_SLEEP; // [R9]
         end
         if (watchdog_fail_count_evt) begin
            stat_q.watchdog_fail_count <= (wd_fails_q == 2'h0) ? `LPRM_WDFAIL_ONE
               : `LPRM_WDFAIL_TWO; // [R22]
         end
         if (uv && restart_evt) begin
            stat_q.main_undervolt_flag <= 1'b1; // [R22]
         end
         if (ov) begin
            stat_q.main_overvolt_flag <= 1'b1; // [R22]
         end
         if (stop_write_bad || sleep_bad) begin
            stat_q.spi_fault <= 1'b1; // [R1] [R5] [R10]
         end
         if ((watchdog_fail_count_evt && (cfg1_bit || wd_fails_q != 2'h0)) || ov_evt) begin
            fail_output <= 1'b1; // [R20]
         end else if (fail_clear && !in_restart) begin
            fail_output <= 1'b0;
         end
      end
   end

   // Pin outputs: reset low in Restart, Sleep and fail-safe, interrupt on wake
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reset_out_n <= 1'b0;
         wd_long_open <= 1'b0;
         interrupt_out_n <= 1'b1;
         int_stop_q <= 1'b0;
         main_supply_on <= 1'b1;
         watchdog_run <= 1'b0;
         io_enable <= 1'b0;
      end else begin
         reset_out_n <= !(state_d == lprm_pkg::ST_RESTART || state_d == lprm_pkg::ST_SLEEP
            || state_d == lprm_pkg::ST_FAILSAFE); // [R18] [R9]
         wd_long_open <= leave_restart; // [R19]
         int_stop_q <= (enter_stop && any_flag) // [R4]
            || ((in_stop || state_q == lprm_pkg::ST_NORMAL) && |wake_hit); // [R2]
         interrupt_out_n <= !int_stop_q;
         main_supply_on <= !(state_d == lprm_pkg::ST_SLEEP
            || state_d == lprm_pkg::ST_FAILSAFE); // [R3] [R9]
         watchdog_run <= (state_d == lprm_pkg::ST_NORMAL || state_d == lprm_pkg::ST_STOP
            || state_d == lprm_pkg::ST_INIT); // [R9]
         io_enable <= !(state_d == lprm_pkg::ST_SLEEP || state_d == lprm_pkg::ST_FAILSAFE
            || state_d == lprm_pkg::ST_RESTART); // [R9] [R21]
      end
   end
endmodule
`default_nettype wire

/* lprm_defines.svh */
// Constants for the low-power / restart mode controller
`ifndef LPRM_DEFINES_SVH
`define LPRM_DEFINES_SVH
`define LPRM_CLK_MHZ 25
`define LPRM_RESET_DELAY_US 10
`define LPRM_RESET_DELAY_CYC (`LPRM_RESET_DELAY_US * `LPRM_CLK_MHZ)
`define LPRM_WD_PERIOD_DEFAULT 3'h4
`define LPRM_DEVSTAT_NONE 2'h0
`define LPRM_DEVSTAT_RESTART 2'h1
`define LPRM_DEVSTAT_SLEEP 2'h2
`define LPRM_WDFAIL_ONE 2'h1
`define LPRM_WDFAIL_TWO 2'h2
`define LPRM_CMD_NORMAL 2'h0
`define LPRM_CMD_SLEEP 2'h1
`define LPRM_CMD_STOP 2'h2
`define LPRM_CMD_SOFTRST 2'h3
`define LPRM_TRX_OFF 2'h0
`define LPRM_TRX_WAKE 2'h1
`define LPRM_TRX_RXONLY 2'h2
`define LPRM_TRX_ON 2'h3
`endif

/* lprm_pkg.sv */
// Types for the low-power / restart mode controller
package lprm_pkg;
   typedef enum logic [2:0] {
      ST_INIT = 3'h0,
      ST_NORMAL = 3'h1,
      ST_STOP = 3'h2,
      ST_SLEEP = 3'h3,
      ST_RESTART = 3'h4,
      ST_FAILSAFE = 3'h5
   } lprm_state_t;

   // Mode command from the SPI decoder
   typedef struct packed {
      logic valid;
      logic is_write;
      logic [1:0] mode;
      logic mode_write;
      logic wd_refresh;
      logic status_clear;
   } lprm_cmd_t;

   // Wake enables and sources
   typedef struct packed {
      logic trx;
      logic sense;
      logic gpio;
      logic timer;
   } lprm_wake_t;

   // Settings frozen in low-power modes
   typedef struct packed {
      logic aux_on;
      logic [1:0] trx_mode;
      logic sense_en;
      logic cyc_sense;
      logic cyc_wake;
      logic [2:0] wd_period;
      logic cp_on;
      logic gpio_sw_on;
   } lprm_cfg_t;

   // Status bits read by software
   typedef struct packed {
      logic [1:0] device_state_field;
      logic [1:0] watchdog_fail_count;
      logic main_undervolt_flag;
      logic main_overvolt_flag;
      logic spi_fault;
   } lprm_stat_t;
endpackage

/* lprm_ctrl_monitor.sv */
// Concurrent checks on the ports of the mode controller
`timescale 1ns/1ps
`default_nettype none
`include "lprm_defines.svh"
module lprm_ctrl_monitor #(
   parameter int RESET_DELAY_CYC = `LPRM_RESET_DELAY_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire lprm_pkg::lprm_cmd_t cmd,
   input wire logic fail_clear,
   input wire lprm_pkg::lprm_state_t state_q,
   input wire lprm_pkg::lprm_cfg_t cfg_q,
   input wire lprm_pkg::lprm_stat_t stat_q,
   input wire logic reset_out_n,
   input wire logic fail_output,
   input wire logic main_supply_on,
   input wire logic watchdog_run,
   input wire logic wd_long_open,
   input wire logic io_enable
);
   int unsigned rst_cnt_q;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Cycles spent in Restart; a counter keeps the bound cheap for long delays
   always_ff @(posedge clock) begin
      if (!rst_n || state_q != lprm_pkg::ST_RESTART) begin
         rst_cnt_q <= 0;
      end else begin
         rst_cnt_q <= rst_cnt_q + 1;
      end
   end
   property p_stop_write;
      state_q == lprm_pkg::ST_STOP && cmd.valid && cmd.is_write && !cmd.mode_write
         && !cmd.wd_refresh && !cmd.status_clear |=> stat_q.spi_fault;
   endproperty
   a_stop_write: assert property (p_stop_write) else $error("stop write not flagged");
   property p_stop_frozen;
      state_q == lprm_pkg::ST_STOP && $past(state_q) == lprm_pkg::ST_STOP
         |-> $stable(cfg_q) && main_supply_on;
   endproperty
   a_stop_frozen: assert property (p_stop_frozen) else $error("stop settings moved");
   property p_stop_sleep;
      state_q == lprm_pkg::ST_STOP && cmd.valid && cmd.mode_write
         && cmd.mode == `LPRM_CMD_SLEEP |=> state_q == lprm_pkg::ST_RESTART && stat_q.spi_fault;
   endproperty
   a_stop_sleep: assert property (p_stop_sleep) else $error("stop to sleep not refused");
   property p_sleep_off;
      state_q == lprm_pkg::ST_SLEEP && $past(state_q) == lprm_pkg::ST_SLEEP
         |-> !main_supply_on && !watchdog_run && !io_enable && !reset_out_n;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("sleep outputs wrong");
   property p_restart_rst;
      state_q == lprm_pkg::ST_RESTART |-> !reset_out_n;
   endproperty
   a_restart_rst: assert property (p_restart_rst) else $error("reset high in restart");
   property p_restart_exit;
      state_q == lprm_pkg::ST_RESTART ##1 state_q != lprm_pkg::ST_RESTART
         |-> state_q == lprm_pkg::ST_NORMAL && reset_out_n;
   endproperty
   a_restart_exit: assert property (p_restart_exit) else $error("restart exit wrong");
   property p_restart_len;
      rst_cnt_q <= RESET_DELAY_CYC + 1;
   endproperty
   a_restart_len: assert property (p_restart_len) else $error("restart too long");
   property p_long_open;
      $rose(reset_out_n) && $past(state_q) == lprm_pkg::ST_RESTART
         |-> wd_long_open && cfg_q.wd_period == `LPRM_WD_PERIOD_DEFAULT;
   endproperty
   a_long_open: assert property (p_long_open) else $error("no long open window");
   property p_restart_aux;
      state_q == lprm_pkg::ST_RESTART && $past(state_q) == lprm_pkg::ST_RESTART |-> !cfg_q.aux_on;
   endproperty
   a_restart_aux: assert property (p_restart_aux) else $error("aux on in restart");
   property p_fail_hold;
      fail_output && !fail_clear |=> fail_output;
   endproperty
   a_fail_hold: assert property (p_fail_hold) else $error("fail output dropped");
endmodule
bind lprm_ctrl lprm_ctrl_monitor #(.RESET_DELAY_CYC(RESET_DELAY_CYC)) u_mon (.clock(clock),
   .rst_n(rst_n), .cmd(cmd), .fail_clear(fail_clear), .state_q(state_q), .cfg_q(cfg_q),
   .stat_q(stat_q), .reset_out_n(reset_out_n), .fail_output(fail_output),
   .main_supply_on(main_supply_on), .watchdog_run(watchdog_run),
   .wd_long_open(wd_long_open), .io_enable(io_enable));
`default_nettype wire

/* lprm_mcu_model.sv */
// Microcontroller model: sends decoded SPI words, counts cycles with the interrupt line low
`timescale 1ns/1ps
`default_nettype none
module lprm_mcu_model (
   input wire logic clock,
   input wire logic interrupt_out_n,
   input wire logic reset_out_n,
   output var lprm_pkg::lprm_cmd_t cmd
);
   int int_count = 0;
   initial cmd = '0;
   // Each low cycle of the interrupt line is one event seen by software
   always @(posedge clock) begin
      if (reset_out_n === 1'b1 && interrupt_out_n === 1'b0) begin
         int_count <= int_count + 1;
      end
   end
   // One word per call; an idle edge follows so back-to-back calls never collide
   task automatic send(input logic mw, input logic [1:0] m, input logic wr,
                       input logic rf, input logic cl);
      @(negedge clock);
      cmd <= '{valid: 1'b1, is_write: wr, mode: m, mode_write: mw,
               wd_refresh: rf, status_clear: cl};
      @(negedge clock);
      cmd <= '0;
   endtask
   // Wake flags are cleared before any low-power request
   task automatic enter_low_power(input logic [1:0] m);
      send(1'b0, 2'h0, 1'b0, 1'b0, 1'b1);
      send(1'b1, m, 1'b1, 1'b0, 1'b0);
   endtask
endmodule
`default_nettype wire

/* tb_low_power_restart_mode_controller.sv */
// Self-checking bench for the low-power and restart mode controller
`timescale 1ns/1ps
`default_nettype none
`include "lprm_defines.svh"
module tb_low_power_restart_mode_controller;
   typedef struct packed {
      logic [1:0] m1;
      logic [1:0] m2;
      logic [2:0] st;
      logic flt;
   } lprm_row_t;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic measurement_select = 1'b0, ov_en = 1'b0, cfg1_bit = 1'b0, config0_pin = 1'b1;
   logic main_uv_pin = 1'b0, main_ov_pin = 1'b0, wd_bad_trigger = 1'b0;
   logic thermal_shutdown_level2_pin = 1'b0, fail_clear = 1'b0, cfg_lock = 1'b0;
   lprm_pkg::lprm_cmd_t cmd;
   lprm_pkg::lprm_cfg_t cfg_wr = 11'h621, cfg_q;
   lprm_pkg::lprm_wake_t wake_en_wr = 4'hC, wake_evt_in = 4'h0, wake_status_q;
   lprm_pkg::lprm_state_t state_q;
   lprm_pkg::lprm_stat_t stat_q;
   logic interrupt_out_n, reset_out_n, fail_output, main_supply_on;
   logic watchdog_run, wd_long_open, io_enable;
   int fail_count = 0;
   int checked = 0;
   int n0;
   lprm_row_t rows[4] = '{'{`LPRM_CMD_STOP, `LPRM_CMD_NORMAL, 3'h1, 1'b0},
      '{`LPRM_CMD_STOP, `LPRM_CMD_SOFTRST, 3'h0, 1'b0},
      '{`LPRM_CMD_STOP, `LPRM_CMD_SLEEP, 3'h4, 1'b1},
      '{`LPRM_CMD_NORMAL, `LPRM_CMD_STOP, 3'h2, 1'b0}};
   // Short reset delay keeps every restart a few cycles long
   lprm_ctrl #(.RESET_DELAY_CYC(4)) dut (.clock(clock), .rst_n(rst_n), .cmd(cmd),
      .cfg_wr(cfg_wr), .wake_en_wr(wake_en_wr), .cfg_lock(cfg_lock),
      .measurement_select(measurement_select), .main_overvolt_reset_enable(ov_en),
      .cfg1_bit(cfg1_bit), .config0_pin(config0_pin), .main_uv_pin(main_uv_pin),
      .main_ov_pin(main_ov_pin), .thermal_shutdown_level2_pin(thermal_shutdown_level2_pin), .wake_evt_in(wake_evt_in),
      .wd_bad_trigger(wd_bad_trigger), .fail_clear(fail_clear), .state_q(state_q), .cfg_q(cfg_q),
      .wake_status_q(wake_status_q), .stat_q(stat_q), .interrupt_out_n(interrupt_out_n),
      .reset_out_n(reset_out_n), .fail_output(fail_output), .main_supply_on(main_supply_on),
      .watchdog_run(watchdog_run), .wd_long_open(wd_long_open), .io_enable(io_enable));
   lprm_mcu_model mcu (.clock(clock), .interrupt_out_n(interrupt_out_n),
      .reset_out_n(reset_out_n), .cmd(cmd));
   initial begin
      forever #20 clock = ~clock;
   end
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_st(input logic [2:0] s);
      int n = 0;
      while (state_q !== s && n < 40) begin
         @(negedge clock);
         n++;
      end
      chk(12'(state_q), 12'(s));
   endtask
   // Restart must finish first, since words sent during it are dropped
   task automatic go_normal;
      int n = 0;
      while (state_q === lprm_pkg::ST_RESTART && n < 40) begin
         @(negedge clock);
         n++;
      end
      mcu.send(1'b1, `LPRM_CMD_NORMAL, 1'b1, 1'b0, 1'b0);
      mcu.send(1'b0, 2'h0, 1'b0, 1'b0, 1'b1);
      chk(12'(state_q), 12'(lprm_pkg::ST_NORMAL));
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge clock);
      fail_count++;
      end_of_test();
   end
   initial begin
      repeat (16) @(negedge clock);
      rst_n = 1'b1;
      @(negedge clock);
      chk(12'({reset_out_n, interrupt_out_n, main_supply_on}), 12'h007);
      chk(12'(cfg_q.wd_period), 12'(`LPRM_WD_PERIOD_DEFAULT));
      mcu.send(1'b1, `LPRM_CMD_NORMAL, 1'b1, 1'b0, 1'b0);
      $display("reset test done");
      foreach (rows[i]) begin
         go_normal();
         mcu.send(1'b1, rows[i].m1, 1'b1, 1'b0, 1'b0);
         mcu.send(1'b1, rows[i].m2, 1'b1, 1'b0, 1'b0);
         chk(12'(state_q), 12'(rows[i].st));
         chk(12'(stat_q.spi_fault), 12'(rows[i].flt));
      end
      $display("mode table done");
      go_normal();
      mcu.send(1'b0, 2'h0, 1'b1, 1'b0, 1'b0);
      mcu.enter_low_power(`LPRM_CMD_STOP);
      cfg_wr = 11'h000;
      mcu.send(1'b0, 2'h0, 1'b1, 1'b0, 1'b0);
      @(negedge clock);
      chk(12'(cfg_q), 12'h621);
      chk(12'({stat_q.spi_fault, main_supply_on}), 12'h003);
      $display("stop write test done");
      n0 = mcu.int_count;
      wake_evt_in = 4'h8;
      repeat (3) @(negedge clock);
      wake_evt_in = 4'h0;
      repeat (6) @(negedge clock);
      chk(12'(mcu.int_count != n0), 12'h001);
      chk(12'(state_q), 12'(lprm_pkg::ST_STOP));
      mcu.send(1'b1, `LPRM_CMD_NORMAL, 1'b1, 1'b0, 1'b0);
      n0 = mcu.int_count;
      mcu.send(1'b1, `LPRM_CMD_STOP, 1'b1, 1'b0, 1'b0);
      repeat (6) @(negedge clock);
      chk(12'(mcu.int_count != n0), 12'h001);
      mcu.send(1'b1, `LPRM_CMD_NORMAL, 1'b1, 1'b0, 1'b0);
      mcu.send(1'b1, `LPRM_CMD_SLEEP, 1'b1, 1'b0, 1'b0);
      wait_st(lprm_pkg::ST_RESTART);
      wait_st(lprm_pkg::ST_NORMAL);
      $display("stop wake test done");
      go_normal();
      cfg_wr = 11'h621;
      mcu.send(1'b0, 2'h0, 1'b1, 1'b0, 1'b0);
      mcu.enter_low_power(`LPRM_CMD_SLEEP);
      @(negedge clock);
      chk(12'(state_q), 12'(lprm_pkg::ST_SLEEP));
      chk(12'(cfg_q.trx_mode), 12'(`LPRM_TRX_WAKE));
      chk(12'({reset_out_n, main_supply_on}), 12'h000);
      chk(12'(stat_q.device_state_field), 12'(`LPRM_DEVSTAT_SLEEP));
      wake_evt_in = 4'h8;
      wait_st(lprm_pkg::ST_RESTART);
      wake_evt_in = 4'h0;
      wait_st(lprm_pkg::ST_NORMAL);
      chk(12'({wake_status_q.trx, reset_out_n}), 12'h003);
      chk(12'(stat_q.device_state_field), 12'(`LPRM_DEVSTAT_SLEEP));
      go_normal();
      wake_en_wr = 4'h0;
      mcu.send(1'b0, 2'h0, 1'b1, 1'b0, 1'b0);
      mcu.enter_low_power(`LPRM_CMD_SLEEP);
      chk(12'({state_q, stat_q.spi_fault}), 12'h009);
      $display("sleep test done");
      go_normal();
      measurement_select = 1'b1;
      wake_en_wr = 4'h6;
      mcu.send(1'b0, 2'h0, 1'b1, 1'b0, 1'b0);
      mcu.enter_low_power(`LPRM_CMD_STOP);
      n0 = mcu.int_count;
      wake_evt_in = 4'h6;
      repeat (8) @(negedge clock);
      wake_evt_in = 4'h0;
      chk(12'(mcu.int_count != n0), 12'h000);
      measurement_select = 1'b0;
      $display("measurement test done");
      go_normal();
      main_uv_pin = 1'b1;
      repeat (3) @(negedge clock);
      main_uv_pin = 1'b0;
      wait_st(lprm_pkg::ST_RESTART);
      wait_st(lprm_pkg::ST_NORMAL);
      chk(12'({stat_q.main_undervolt_flag, stat_q.device_state_field}), 12'h005);
      go_normal();
      main_ov_pin = 1'b1;
      repeat (3) @(negedge clock);
      main_ov_pin = 1'b0;
      repeat (6) @(negedge clock);
      chk(12'({state_q, fail_output}), 12'h002);
      mcu.send(1'b0, 2'h0, 1'b0, 1'b0, 1'b1);
      ov_en = 1'b1;
      main_ov_pin = 1'b1;
      repeat (3) @(negedge clock);
      main_ov_pin = 1'b0;
      wait_st(lprm_pkg::ST_RESTART);
      wait_st(lprm_pkg::ST_NORMAL);
      chk(12'({stat_q.main_overvolt_flag, fail_output}), 12'h003);
      thermal_shutdown_level2_pin = 1'b1;
      repeat (4) @(negedge clock);
      chk(12'(state_q), 12'(lprm_pkg::ST_FAILSAFE));
      thermal_shutdown_level2_pin = 1'b0;
      wait_st(lprm_pkg::ST_RESTART);
      wait_st(lprm_pkg::ST_NORMAL);
      $display("supply test done");
      go_normal();
      fail_clear = 1'b1;
      @(negedge clock);
      fail_clear = 1'b0;
      chk(12'(fail_output), 12'h000);
      cfg1_bit = 1'b1;
      wd_bad_trigger = 1'b1;
      @(negedge clock);
      wd_bad_trigger = 1'b0;
      wait_st(lprm_pkg::ST_RESTART);
      wait_st(lprm_pkg::ST_NORMAL);
      chk(12'({stat_q.watchdog_fail_count, fail_output}), 12'h003);
      $display("watchdog test done");
      go_normal();
      mcu.send(1'b0, 2'h0, 1'b1, 1'b0, 1'b0);
      cfg_lock = 1'b1;
      mcu.send(1'b1, `LPRM_CMD_SOFTRST, 1'b1, 1'b0, 1'b0);
      chk(12'(state_q), 12'(lprm_pkg::ST_INIT));
      chk(12'(cfg_q), 12'h621);
      $display("lock test done");
      end_of_test();
   end
endmodule
`default_nettype wire
